// >>> mrm_map.vh
// Purpose: Constants for the remote register map: functions, address regions, timing.
// Assumes: A 40 MHz system clock.
// Notes:   Printed register numbers are protocol addresses plus one.
`ifndef MRM_MAP_VH
`define MRM_MAP_VH

// Function codes and exception codes of the request port.
`define MRM_FN_READ_HOLD     8'h03
`define MRM_FN_WRITE_SINGLE  8'h06
`define MRM_FN_WRITE_MULTI   8'h10
`define MRM_EXC_NONE         8'h00
`define MRM_EXC_BAD_FUNC     8'h01
`define MRM_EXC_BAD_ADDR     8'h02
`define MRM_EXC_BAD_VALUE    8'h03

// Printed register number is the address plus this bias.
`define MRM_NUMBER_BIAS      16'h0001

// Regions inside one view, as protocol addresses, and the largest read quantity.
`define MRM_DISP_FIRST       16'h0000
`define MRM_DISP_LAST        16'h0028
`define MRM_ENG_FIRST        16'h0064
`define MRM_ENG_LAST         16'h012c
`define MRM_CTL_FIRST        16'h0320
`define MRM_CTL_LAST         16'h032f
`define MRM_READ_MAX_QTY     16'h007d

// View offsets: second burner and water-level unit.
`define MRM_SECOND_BASE      16'h2710
`define MRM_LEVEL_BASE       16'h4e20

// Writable register range and default.
`define MRM_CTL_MAX          16'h03e7
`define MRM_CTL_DEFAULT      16'h0000

// Refresh timeout.
`define MRM_CLK_HZ           40000000
`define MRM_REFRESH_TIME_S   60
`define MRM_TICK_CYCLES      (`MRM_CLK_HZ * 1)

// Named read-only holding addresses.
`define MRM_DRIVE0_POSITION  16'h0000
`define MRM_DRIVE1_POSITION  16'h0001
`define MRM_DRIVE2_POSITION  16'h0002
`define MRM_DRIVE3_POSITION  16'h0003
`define MRM_DRIVE4_POSITION  16'h0004
`define MRM_DRIVE5_POSITION  16'h0005
`define MRM_DRIVE6_POSITION  16'h0006
`define MRM_DRIVE7_POSITION  16'h0007
`define MRM_LEVEL_UNIT_DRAFT_PRESSURE    16'h503c
`define MRM_LEVEL_UNIT_DRAFT_OUTPUT      16'h503e
`define MRM_LEVEL_UNIT_DRAFT_SETPOINT    16'h5040
`define MRM_LEVEL_UNIT_PROGRAM_REVISION  16'h5078

`endif

// >>> mrm_sec_tick.v
// Purpose: One-cycle tick once per second of the system clock.
// Assumes: TICK_CYCLES is at least 2.
// Notes:   Shorten TICK_CYCLES in simulation.
`timescale 1ns/1ps
`include "mrm_map.vh"
module mrm_sec_tick #(
    parameter [31:0] TICK_CYCLES = `MRM_TICK_CYCLES
) (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        nrst,
    // Tick
    output reg         tick
);

    reg [31:0] count;

    // Free-running divider; tick marks the wrap.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count <= 32'h0;
            tick  <= 1'b0;
        end else if (count == TICK_CYCLES - 32'h1) begin
            count <= 32'h0;
            tick  <= 1'b1;
        end else begin
            count <= count + 32'h1;
            tick  <= 1'b0;
        end
    end

endmodule // mrm_sec_tick

// >>> mrm_ctl_slot.v
// Purpose: One writable remote-control register with range check and refresh timeout.
// Assumes: sec_tick pulses once a second.
// Notes:   Timeout falls between 60 and 61 seconds after the last write.
`timescale 1ns/1ps
`include "mrm_map.vh"
module mrm_ctl_slot (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        nrst,
    // Write and time base
    input  wire        wr_stb,
    input  wire [15:0] wr_data,
    input  wire        sec_tick,
    // Control output
    output reg  [15:0] value,
    output reg         active
);

    reg [6:0] secs;
    wire      in_range;

    // Signed value must lie within 0 to the range limit.
    assign in_range = !wr_data[15] && (wr_data <= `MRM_CTL_MAX);

    // Write loads or disables; missing refresh reverts to default.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            value  <= `MRM_CTL_DEFAULT;
            active <= 1'b0;
            secs   <= 7'h0;
        end else if (wr_stb) begin
            secs <= 7'h0;
            if (in_range) begin
                value  <= wr_data;
                active <= 1'b1;
            end else begin
                value  <= `MRM_CTL_DEFAULT;
                active <= 1'b0;
            end
        end else if (active && sec_tick) begin
            if (secs == `MRM_REFRESH_TIME_S) begin
                value  <= `MRM_CTL_DEFAULT;
                active <= 1'b0;
                secs   <= 7'h0;
            end else begin
                secs <= secs + 7'h1;
            end
        end
    end

endmodule // mrm_ctl_slot

// >>> mrm_register_map.v
// Purpose: Remote holding-register map: reads of display, engineer and control values,
//          single writes of sixteen control registers per view.
// Assumes: val_data answers val_bank, val_is_eng and val_index in the same cycle.
// Notes:   One request at a time; req_ready is high only when idle.
//
// Summary of operation
// - Holding registers read by function 3, written singly by function 6.
// - Function 16 is not supported; the master must not use it.
// - Sixteen writable 16-bit registers sit at addresses 800 to 815.
// - Printed register number is the address plus one.
// - Value outside 0 to 999 disables the item and restores its default.
// - Without a rewrite for a minute the item times out to default.
// - Display values 0 to 40 read as read-only holding registers.
// - Engineer values 0 to 200 read as read-only holding registers.
// - All values are 16-bit signed integers, fractions scaled by ten powers.
// - Each item keeps its fixed scaling in normal operation.
// - Second burner view appears at address plus 10000 in twin mode.
// - Water-level unit view appears at address plus 20000 when present.
`timescale 1ns/1ps
`include "mrm_map.vh"
module mrm_register_map #(
    parameter [31:0] TICK_CYCLES = `MRM_TICK_CYCLES
) (
    // Clock and reset
    input  wire         sys_clk,
    input  wire         nrst,
    // Request from the protocol engine
    input  wire         req_valid,
    output wire         req_ready,
    input  wire [7:0]   req_func,
    input  wire [15:0]  req_addr,
    input  wire [15:0]  req_word,
    // Answer to the protocol engine
    output reg          rsp_valid,
    output reg  [7:0]   rsp_func,
    output reg  [7:0]   rsp_exc,
    output reg  [15:0]  rsp_addr,
    output reg  [15:0]  rsp_data,
    output reg          rsp_last,
    // Read-only value source
    output reg  [1:0]   val_bank,
    output reg          val_is_eng,
    output reg  [8:0]   val_index,
    input  wire [15:0]  val_data,
    // Configuration
    input  wire         twin_mode,
    input  wire         level_unit_present,
    // Remote-control values, sixteen per view, three views
    output wire [767:0] ctl_value,
    output wire [47:0]  ctl_active
);

    // Regions inside one view.
    localparam [1:0] RG_NONE = 2'h0;
    localparam [1:0] RG_DISP = 2'h1;
    localparam [1:0] RG_ENG  = 2'h2;
    localparam [1:0] RG_CTL  = 2'h3;

    // Controller states.
    localparam       ST_IDLE = 1'b0;
    localparam       ST_READ = 1'b1;

    // Splits an address into view number and local address.
    function [17:0] mrm_split;
        input [15:0] a;
        begin
            if (a >= `MRM_LEVEL_BASE)
                mrm_split = {2'h2, a - `MRM_LEVEL_BASE};
            else if (a >= `MRM_SECOND_BASE)
                mrm_split = {2'h1, a - `MRM_SECOND_BASE};
            else
                mrm_split = {2'h0, a};
        end
    endfunction

    // Classifies a local address into its region.
    function [1:0] mrm_region;
        input [15:0] a;
        begin
            if (a <= `MRM_DISP_LAST)
                mrm_region = RG_DISP;
            else if (a >= `MRM_ENG_FIRST && a <= `MRM_ENG_LAST)
                mrm_region = RG_ENG;
            else if (a >= `MRM_CTL_FIRST && a <= `MRM_CTL_LAST)
                mrm_region = RG_CTL;
            else
                mrm_region = RG_NONE;
        end
    endfunction

    // Index of a display or engineer value within its list.
    function [8:0] mrm_val_index;
        input [1:0]  rg;
        input [15:0] a;
        reg   [15:0] d;
        begin
            d = a - `MRM_ENG_FIRST;
            mrm_val_index = (rg == RG_ENG) ? d[8:0] : a[8:0];
        end
    endfunction

    reg         state;
    reg  [1:0]  cur_bank;
    reg  [15:0] cur_local;
    reg  [15:0] cur_abs;
    reg  [1:0]  cur_region;
    reg  [15:0] remaining;

    reg  [17:0] split;
    reg  [1:0]  req_bank;
    reg  [15:0] req_local;
    reg  [16:0] end_wide;
    reg  [1:0]  rg_start;
    reg  [1:0]  rg_end;
    reg         bank_ok;
    reg         qty_ok;
    reg         rd_ok;
    reg         wr_ok;
    reg  [15:0] ctl_off;
    reg  [15:0] next_local;
    reg  [15:0] cur_off;

    wire        wr_fire;
    wire [5:0]  wr_sel;
    wire [5:0]  rd_sel;
    wire        sec_tick;

    assign req_ready = (state == ST_IDLE);

    // Decode of the offered request: view, region, quantity and legality.
    always @* begin
        split     = mrm_split(req_addr);
        req_bank  = split[17:16];
        req_local = split[15:0];
        end_wide  = {1'b0, req_local} + {1'b0, req_word} - 17'h1;
        rg_start  = mrm_region(req_local);
        rg_end    = mrm_region(end_wide[15:0]);
        bank_ok   = (req_bank == 2'h0) ||
                    (req_bank == 2'h1 && twin_mode) ||
                    (req_bank == 2'h2 && level_unit_present);
        qty_ok    = (req_word != 16'h0) && (req_word <= `MRM_READ_MAX_QTY);
        rd_ok     = bank_ok && (rg_start != RG_NONE) && (rg_start == rg_end) &&
                    !end_wide[16];
        wr_ok     = bank_ok && (rg_start == RG_CTL);
        ctl_off   = req_local - `MRM_CTL_FIRST;
        next_local = cur_local + 16'h1;
        cur_off   = cur_local - `MRM_CTL_FIRST;
    end

    // A single write to a writable address of a present view.
    assign wr_fire = req_valid && (state == ST_IDLE) &&
                     (req_func == `MRM_FN_WRITE_SINGLE) && wr_ok;
    assign wr_sel  = {req_bank, ctl_off[3:0]};
    assign rd_sel  = {cur_bank, cur_off[3:0]};

    mrm_sec_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .tick    (sec_tick)
    );

    // One control slot per writable address in each of the three views.
    genvar g;
    generate
        for (g = 0; g < 48; g = g + 1) begin : gen_slot
            mrm_ctl_slot u_slot (
                .sys_clk  (sys_clk),
                .nrst     (nrst),
                .wr_stb   (wr_fire && (wr_sel == g)),
                .wr_data  (req_word),
                .sec_tick (sec_tick),
                .value    (ctl_value[g*16 +: 16]),
                .active   (ctl_active[g])
            );
        end
    endgenerate

    // Request handling and answer generation; reads stream one word a cycle.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state      <= ST_IDLE;
            rsp_valid  <= 1'b0;
            rsp_func   <= 8'h00;
            rsp_exc    <= `MRM_EXC_NONE;
            rsp_addr   <= 16'h0000;
            rsp_data   <= 16'h0000;
            rsp_last   <= 1'b0;
            val_bank   <= 2'h0;
            val_is_eng <= 1'b0;
            val_index  <= 9'h000;
            cur_bank   <= 2'h0;
            cur_local  <= 16'h0000;
            cur_abs    <= 16'h0000;
            cur_region <= RG_NONE;
            remaining  <= 16'h0000;
        end else begin
            rsp_valid <= 1'b0;
            rsp_last  <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (req_valid) begin
                        rsp_func <= req_func;
                        rsp_addr <= req_addr;
                        case (req_func)
                            `MRM_FN_READ_HOLD: begin
                                if (!qty_ok) begin
                                    rsp_valid <= 1'b1;
                                    rsp_last  <= 1'b1;
                                    rsp_exc   <= `MRM_EXC_BAD_VALUE;
                                    rsp_data  <= 16'h0000;
                                end else if (!rd_ok) begin
                                    rsp_valid <= 1'b1;
                                    rsp_last  <= 1'b1;
                                    rsp_exc   <= `MRM_EXC_BAD_ADDR;
                                    rsp_data  <= 16'h0000;
                                end else begin
                                    // Reads of display, engineer and control values.
                                    rsp_exc    <= `MRM_EXC_NONE;
                                    cur_bank   <= req_bank;
                                    cur_local  <= req_local;
                                    cur_abs    <= req_addr;
                                    cur_region <= rg_start;
                                    remaining  <= req_word;
                                    val_bank   <= req_bank;
                                    val_is_eng <= (rg_start == RG_ENG);
                                    val_index  <= mrm_val_index(rg_start, req_local);
                                    state      <= ST_READ;
                                end
                            end
                            `MRM_FN_WRITE_SINGLE: begin
                                rsp_valid <= 1'b1;
                                rsp_last  <= 1'b1;
                                rsp_data  <= wr_ok ? req_word : 16'h0000;
                                rsp_exc   <= wr_ok ? `MRM_EXC_NONE
                                                   : `MRM_EXC_BAD_ADDR;
                            end
                            default: begin
                                // Write-multiple and all other functions are refused.
                                rsp_valid <= 1'b1;
                                rsp_last  <= 1'b1;
                                rsp_exc   <= `MRM_EXC_BAD_FUNC;
                                rsp_data  <= 16'h0000;
                            end
                        endcase
                    end
                end
                ST_READ: begin
                    // Values pass through unchanged: signed, scaled by the source.
                    rsp_valid <= 1'b1;
                    rsp_addr  <= cur_abs;
                    rsp_data  <= (cur_region == RG_CTL) ? ctl_value[rd_sel*16 +: 16]
                                                        : val_data;
                    cur_abs   <= cur_abs + 16'h1;
                    cur_local <= next_local;
                    val_index <= mrm_val_index(cur_region, next_local);
                    remaining <= remaining - 16'h1;
                    if (remaining == 16'h1) begin
                        rsp_last <= 1'b1;
                        state    <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // mrm_register_map

// >>> mrm_value_source.sv
// Purpose: Value source model answering the map's read-only value lookups.
// Assumes: Lookups are answered combinationally in the same cycle.
// Notes:   Each word encodes view, list and index; odd indexes give negative words.
`timescale 1ns/1ps
module mrm_value_source (
    // Lookup from the map
    input  wire [1:0]  val_bank,
    input  wire        val_is_eng,
    input  wire [8:0]  val_index,
    // Answer
    output wire [15:0] val_data
);
    // Fixed encoding per item, signed words on odd indexes.
    assign val_data = {val_index[0] ? 4'hc : 4'h3, val_bank, val_is_eng, val_index};
endmodule // mrm_value_source

// >>> mrm_map_monitor.sv
// Purpose: Concurrent checks on the register map's request and answer ports.
// Assumes: One clock domain, reset active low.
// Notes:   Slot checks cover the first burner view.
`timescale 1ns/1ps
module mrm_map_monitor #(
    parameter [31:0] TICK_CYCLES = 32'h0262_5a00
) (
    // Clock and reset
    input wire         sys_clk,
    input wire         nrst,
    // Request and answer
    input wire         req_valid,
    input wire         req_ready,
    input wire [7:0]   req_func,
    input wire [15:0]  req_addr,
    input wire [15:0]  req_word,
    input wire         rsp_valid,
    input wire [7:0]   rsp_func,
    input wire [7:0]   rsp_exc,
    input wire [15:0]  rsp_addr,
    input wire [15:0]  rsp_data,
    input wire         rsp_last,
    // Values, configuration and control outputs
    input wire [15:0]  val_data,
    input wire         twin_mode,
    input wire         level_unit_present,
    input wire [767:0] ctl_value,
    input wire [47:0]  ctl_active
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Request decode shared by the checks.
    wire take = req_valid && req_ready;
    wire ctl_hit = req_addr >= 16'h0320 && req_addr <= 16'h032f;
    wire wr = take && req_func == 8'h06;
    wire rd1 = take && req_func == 8'h03 && req_word == 16'h0001;
    reg [3:0] wslot;
    // Slot of the request offered in the previous cycle.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) wslot <= 4'h0;
        else wslot <= req_addr[3:0];
    end
    chk_write_echo: assert property (wr && ctl_hit |=> rsp_valid && rsp_last &&
        rsp_exc == 8'h00 && rsp_data == $past(req_word)) else $error("write echo wrong");
    chk_write_slot: assert property (wr && ctl_hit && req_word <= 16'h03e7 |=>
        ctl_active[wslot] && ctl_value[{wslot, 4'h0} +: 16] == $past(req_word))
        else $error("slot not loaded");
    chk_range_disable: assert property (wr && ctl_hit && req_word > 16'h03e7 |=>
        !ctl_active[wslot] && ctl_value[{wslot, 4'h0} +: 16] == 16'h0000)
        else $error("out of range write kept slot");
    chk_ro_refuse: assert property (wr && !ctl_hit && req_addr < 16'h2710 |=>
        rsp_exc == 8'h02 && $stable(ctl_value)) else $error("read-only write taken");
    chk_func_refuse: assert property (take &&
        req_func != 8'h03 && req_func != 8'h06 |=>
        rsp_valid && rsp_exc == 8'h01 && $stable(ctl_active)) else $error("bad function served");
    chk_qty_refuse: assert property (take && req_func == 8'h03 &&
        (req_word == 16'h0000 || req_word > 16'h007d) |=> rsp_valid && rsp_exc == 8'h03 &&
        rsp_data == 16'h0000) else $error("bad quantity served");
    chk_read_word: assert property (rsp_valid && rsp_func == 8'h03 &&
        rsp_exc == 8'h00 && rsp_addr < 16'h0320 |-> rsp_data == $past(val_data))
        else $error("read word wrong");
    // A read word leaves two edges after the take, when the engine is idle again.
    chk_single_read: assert property (rd1 && req_addr <= 16'h0028 |=> !rsp_valid &&
        !req_ready ##1 rsp_valid && rsp_last && req_ready)
        else $error("single read timing wrong");
    chk_twin_absent: assert property (rd1 && req_addr >= 16'h2710 &&
        req_addr < 16'h4e20 && !twin_mode |=> rsp_exc == 8'h02)
        else $error("absent second view served");
    chk_level_absent: assert property (rd1 && req_addr >= 16'h4e20 &&
        req_addr < 16'h7530 && !level_unit_present |=> rsp_exc == 8'h02)
        else $error("absent level view served");
endmodule // mrm_map_monitor

bind mrm_register_map mrm_map_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_mon (
    .sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
    .req_func(req_func), .req_addr(req_addr), .req_word(req_word), .rsp_valid(rsp_valid),
    .rsp_func(rsp_func), .rsp_exc(rsp_exc), .rsp_addr(rsp_addr), .rsp_data(rsp_data),
    .rsp_last(rsp_last), .val_data(val_data), .twin_mode(twin_mode),
    .level_unit_present(level_unit_present), .ctl_value(ctl_value), .ctl_active(ctl_active)
);

// >>> tb_modbus_remote_register_map.sv
// Purpose: Request-level test of the remote register map.
// Assumes: One-second tick shortened to 20 cycles.
// Notes:   Words from the value source encode their own view, list and index.
`timescale 1ns/1ps
module tb_modbus_remote_register_map;
    reg          sys_clk, nrst, req_valid, twin_mode, level_unit_present;
    reg  [7:0]   req_func, exc;
    reg  [15:0]  req_addr, req_word;
    reg  [15:0]  words [0:127];
    reg  [63:0]  table_v;
    wire         req_ready, rsp_valid, rsp_last, val_is_eng;
    wire [7:0]   rsp_func, rsp_exc;
    wire [15:0]  rsp_addr, rsp_data, val_data;
    wire [1:0]   val_bank;
    wire [8:0]   val_index;
    wire [767:0] ctl_value;
    wire [47:0]  ctl_active;
    integer      nwords, failures, tests_run, k;

    mrm_register_map #(.TICK_CYCLES(32'h14)) i_dut (
        .sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
        .req_func(req_func), .req_addr(req_addr), .req_word(req_word), .rsp_valid(rsp_valid),
        .rsp_func(rsp_func), .rsp_exc(rsp_exc), .rsp_addr(rsp_addr), .rsp_data(rsp_data),
        .rsp_last(rsp_last), .val_bank(val_bank), .val_is_eng(val_is_eng),
        .val_index(val_index), .val_data(val_data), .twin_mode(twin_mode),
        .level_unit_present(level_unit_present), .ctl_value(ctl_value), .ctl_active(ctl_active)
    );
    mrm_value_source i_src (.val_bank(val_bank), .val_is_eng(val_is_eng),
        .val_index(val_index), .val_data(val_data));

    // Clock of 25 ns.
    always #12.5 sys_clk = ~sys_clk;

    // Expected source word for a view, list and index.
    function [15:0] vexp(input [1:0] b, input e, input [8:0] i);
        vexp = {i[0] ? 4'hc : 4'h3, b, e, i};
    endfunction

    // Compares one value and counts it.
    task check(input [47:0] got, input [47:0] want);
        begin
            tests_run = tests_run + 1;
            if (got !== want) begin
                failures = failures + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, want);
            end
        end
    endtask

    // Prints the verdict and ends the run.
    task print_verdict;
        begin
            if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    // Moves on by n cycles to just after a rising edge.
    task step(input integer n);
        begin
            repeat (n) @(posedge sys_clk);
            #1;
        end
    endtask

    // Lets one edge pass so valid is never raised in the step that dropped it,
    // offers one request, holds it until taken, then gathers every answer word.
    task req(input [7:0] f, input [15:0] a, input [15:0] w);
        integer n;
        begin
            step(1);
            req_valid = 1'b1;
            req_func = f;
            req_addr = a;
            req_word = w;
            n = 0;
            while (req_ready !== 1'b1 && n < 200) begin
                step(1);
                n = n + 1;
            end
            step(1);
            req_valid = 1'b0;
            nwords = 0;
            exc = 8'hxx;
            while (n < 400) begin
                if (rsp_valid === 1'b1) begin
                    if (rsp_exc === 8'h00) check(rsp_addr, a + nwords);
                    check(rsp_func, f);
                    words[nwords] = rsp_data;
                    exc = rsp_exc;
                    nwords = nwords + 1;
                    if (rsp_last === 1'b1) n = 500;
                end
                if (n < 400) step(1);
                n = n + 1;
            end
            if (n < 500) begin
                failures = failures + 1;
                print_verdict;
            end
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        nrst = 1'b0;
        req_valid = 1'b0;
        req_func = 8'h00;
        req_addr = 16'h0000;
        req_word = 16'h0000;
        twin_mode = 1'b0;
        level_unit_present = 1'b0;
        failures = 0;
        tests_run = 0;
        step(5);
        check(ctl_active, 0);
        check(req_ready, 1);
        nrst = 1'b1;
        step(1);
        // Control block ends, then read back as one block.
        req(8'h06, 16'h0320, 16'h0005);
        check({exc, words[0]}, 24'h000005);
        check({ctl_active[0], ctl_value[15:0]}, 17'h10005);
        req(8'h06, 16'h032f, 16'h03e7);
        check({ctl_active[15], ctl_value[255:240]}, 17'h103e7);
        req(8'h03, 16'h0320, 16'h0010);
        check({nwords[7:0], words[0], words[15]}, 40'h10_0005_03e7);
        // Out-of-range values disable a live slot.
        for (k = 0; k < 2; k = k + 1) begin
            req(8'h06, 16'h0321, 16'h0007);
            req(8'h06, 16'h0321, k ? 16'hffff : 16'h03e8);
            check({ctl_active[1], ctl_value[31:16]}, 0);
        end
        // Writes outside the control block and unsupported functions.
        table_v = 64'h031f_0330_0000_0064;
        for (k = 0; k < 4; k = k + 1) begin
            req(8'h06, table_v[k*16 +: 16], 16'h0001);
            check({exc, ctl_value[15:0]}, 24'h020005);
        end
        table_v = 64'h10_04_01_ff;
        for (k = 0; k < 4; k = k + 1) begin
            req(table_v[k*8 +: 8], 16'h0320, 16'h0001);
            check({exc, ctl_value[15:0]}, 24'h010005);
        end
        // Display and engineer reads, region edges and quantity limits.
        req(8'h03, 16'h0000, 16'h0001);
        check(words[0], vexp(0, 0, 0));
        req(8'h03, 16'h0027, 16'h0002);
        check({words[0], words[1]}, {vexp(0, 0, 39), vexp(0, 0, 40)});
        req(8'h03, 16'h0028, 16'h0002);
        check(exc, 2);
        req(8'h03, 16'h012b, 16'h0002);
        check({words[0], words[1]}, {vexp(0, 1, 199), vexp(0, 1, 200)});
        req(8'h03, 16'h0064, 16'h007d);
        check({nwords[7:0], words[124]}, {8'h7d, vexp(0, 1, 124)});
        req(8'h03, 16'h0064, 16'h0000);
        check(exc, 3);
        req(8'h03, 16'h0064, 16'h007e);
        check(exc, 3);
        // Second burner and level unit views.
        req(8'h03, 16'h2774, 16'h0001);
        check(exc, 2);
        twin_mode = 1'b1;
        req(8'h03, 16'h2774, 16'h0001);
        check(words[0], vexp(1, 1, 0));
        req(8'h06, 16'h2a30, 16'h0009);
        check({ctl_active[16], ctl_value[271:256]}, 17'h10009);
        req(8'h03, 16'h4f2e, 16'h0001);
        check(exc, 2);
        level_unit_present = 1'b1;
        req(8'h03, 16'h4f2e, 16'h0001);
        check(words[0], vexp(2, 1, 170));
        // Refresh keeps a slot alive; silence for a minute drops it.
        req(8'h06, 16'h5140, 16'h0003);
        step(1180);
        check(ctl_active[32], 1);
        req(8'h06, 16'h5140, 16'h0003);
        step(1180);
        check(ctl_active[32], 1);
        step(80);
        check({ctl_active[32], ctl_value[527:512]}, 0);
        // Reset in mid-run restores defaults; the engine is idle after release.
        nrst = 1'b0;
        step(2);
        check(ctl_active, 0);
        nrst = 1'b1;
        step(2);
        check({req_ready, rsp_valid, rsp_last}, 3'b100);
        print_verdict;
    end
endmodule // tb_modbus_remote_register_map
